// ---- logic/vector_feature_defines.vh ----
`ifndef VECTOR_FEATURE_DEFINES_VH
`define VECTOR_FEATURE_DEFINES_VH

// register field positions (msb, lsb)
`define TOP_RESV_MSB     63
`define TOP_RESV_LSB     48
`define INT8_MM_MSB      47
`define INT8_MM_LSB      44
`define CIPHER_MSB       43
`define CIPHER_LSB       40
`define MID_RESV_MSB     39
`define MID_RESV_LSB     36
`define KECCAK_MSB       35
`define KECCAK_LSB       32
`define LOW_RESV_MSB     31
`define LOW_RESV_LSB     24
`define BFLOAT_MSB       23
`define BFLOAT_LSB       20
`define PERMUTE_MSB      19
`define PERMUTE_LSB      16

// nibble index of each feature field
`define INT8_MM_NIBBLE   4'hb
`define CIPHER_NIBBLE    4'ha
`define KECCAK_NIBBLE    4'h8
`define BFLOAT_NIBBLE    4'h5
`define PERMUTE_NIBBLE   4'h4

// field values
`define FIELD_PRESENT    4'h1
`define FIELD_ABSENT     4'h0

// exception levels
`define LEVEL_ZERO       2'h0
`define LEVEL_ONE        2'h1

// syndrome class of a trapped system-register access
`define TRAP_SYNDROME_CLASS 6'h18

`endif

// ---- logic/vector_feature_id_register.v ----
`timescale 1ns/1ps
`include "vector_feature_defines.vh"

// What this block does
// RULE1 - provide a 64-bit read-only vector feature identification register
// RULE2 - location reads as zero where features are absent, from levels one to three
// RULE3 - bits 63 to 48 always read zero
// RULE4 - int8 matrix multiply field, bits 47 to 44, reads one
// RULE5 - cipher field, bits 43 to 40, one when build_parameter_a enabled, else zero
// RULE6 - keccak field, bits 35 to 32, one when build_parameter_a enabled, else zero
// RULE7 - bits 39 to 36 and 31 to 24 always read zero
// RULE8 - brain float field, bits 23 to 20, reads one
// RULE9 - bit permute field, bits 19 to 16, reads one after reset
// RULE10 - build_parameter_a enabled only if build parameter true and disable low at reset
// RULE11 - level zero reads trap class 0x18; level one traps if enabled
// RULE12 - fields fixed from reset until next reset; writes ignored; code fixes only the build_parameter_a strap, image follows VECTOR_PRESENT
module vector_feature_id_register #(
    parameter BUILD_PARAMETER_A = 1
) (
    input  wire        REF_CLK,
    input  wire        RESETN,
    input  wire        BUILD_PARAMETER_A_DISABLE_INPUT,
    input  wire        VECTOR_PRESENT,
    input  wire        READ_REQUEST,
    input  wire [1:0]  EXCEPTION_LEVEL,
    input  wire        LEVEL_TWO_ENABLED,
    input  wire        ID_GROUP_THREE_TRAP,
    input  wire        HOST_TRAP_GENERAL,
    output reg  [63:0] READ_DATA,
    output reg         READ_VALID,
    output reg         TRAP,
    output reg         TRAP_TO_LEVEL_TWO,
    output reg  [5:0]  TRAP_CLASS
);

    // one-hot reset sequence: capture the strap once, then hold it
    localparam [1:0] SEQ_CAPTURE = 2'b01;
    localparam [1:0] SEQ_STEADY  = 2'b10;

    reg  [1:0]  seq_state;
    reg  [1:0]  next_seq_state;
    reg         build_parameter_a_enabled;
    reg         next_build_parameter_a_enabled;
    reg         trap_now;
    reg         trap_el2;
    reg  [63:0] next_read_data;
    reg         next_read_valid;
    reg         next_trap;
    reg         next_trap_to_level_two;
    reg  [5:0]  next_trap_class;
    wire [63:0] image;
    wire [1:0]  trap_route;

    // code of one feature field, zero when the option behind it is absent
    function [3:0] field_code;
        input present;
        begin
            field_code = present ? `FIELD_PRESENT : `FIELD_ABSENT;
        end
    endfunction

    // one nibble of the image; unlisted nibbles are reserved
    function [3:0] nibble_code;
        input [3:0] index;
        input       vector_on;
        input       build_parameter_a_on;
        begin
            nibble_code = `FIELD_ABSENT;
            // RULE2 zero when absent
            if (vector_on)
            begin
                case (index)
                    // RULE4 int8 matrix field
                    `INT8_MM_NIBBLE: nibble_code = field_code(1'b1);
                    // RULE5 cipher field select
                    `CIPHER_NIBBLE:  nibble_code = field_code(build_parameter_a_on);
                    // RULE6 keccak field select
                    `KECCAK_NIBBLE:  nibble_code = field_code(build_parameter_a_on);
                    // RULE8 brain float field
                    `BFLOAT_NIBBLE:  nibble_code = field_code(1'b1);
                    // RULE9 bit permute field
                    `PERMUTE_NIBBLE: nibble_code = field_code(1'b1);
                    // RULE3 RULE7 reserved nibbles
                    default:         nibble_code = `FIELD_ABSENT;
                endcase
            end
        end
    endfunction

    // {trap, to level two}; level zero always traps, to level two only under the general trap control
    function [1:0] trap_decode;
        input [1:0] level;
        input       el2_on;
        input       group3_trap;
        input       general_trap;
        begin
            trap_decode = 2'b00;
            // RULE11 privilege trap decode
            case (level)
                `LEVEL_ZERO:
                begin
                    trap_decode = {1'b1, el2_on && general_trap};
                end
                `LEVEL_ONE:
                begin
                    trap_decode = (el2_on && group3_trap) ? 2'b11 : 2'b00;
                end
                default:
                begin
                    trap_decode = 2'b00;
                end
            endcase
        end
    endfunction

    // later strap changes are ignored until the next reset
    // RULE10 build_parameter_a strap capture
    always @*
    begin
        next_seq_state      = seq_state;
        next_build_parameter_a_enabled = build_parameter_a_enabled;
        case (seq_state)
            SEQ_CAPTURE:
            begin
                next_seq_state      = SEQ_STEADY;
                next_build_parameter_a_enabled = (BUILD_PARAMETER_A != 0) && !BUILD_PARAMETER_A_DISABLE_INPUT;
            end
            SEQ_STEADY:
            begin
                next_seq_state      = SEQ_STEADY;
                next_build_parameter_a_enabled = build_parameter_a_enabled;
            end
            default:
            begin
                next_seq_state      = SEQ_CAPTURE;
                next_build_parameter_a_enabled = 1'b0;
            end
        endcase
    end

    // strap caught on the first clock after release, not under the async reset
    // RULE12 frozen until next reset
    always @(posedge REF_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            seq_state      <= SEQ_CAPTURE;
            build_parameter_a_enabled <= 1'b0;
        end
        else
        begin
            seq_state      <= next_seq_state;
            build_parameter_a_enabled <= next_build_parameter_a_enabled;
        end
    end

    // RULE1 image built nibble by nibble
    genvar nib;
    generate
        for (nib = 0; nib < 16; nib = nib + 1)
        begin : g_nibble
            localparam [3:0] NIBBLE_INDEX = nib;
            assign image[4*nib+3:4*nib] = nibble_code(NIBBLE_INDEX, VECTOR_PRESENT,
                                                      build_parameter_a_enabled);
        end
    endgenerate

    assign trap_route = trap_decode(EXCEPTION_LEVEL, LEVEL_TWO_ENABLED,
                                    ID_GROUP_THREE_TRAP, HOST_TRAP_GENERAL);

    always @*
    begin
        trap_now = trap_route[1];
        trap_el2 = trap_route[0];
    end

    // a trapped read never shows the image
    // RULE1 RULE12 read-only answer
    always @*
    begin
        next_read_valid        = 1'b0;
        next_trap              = 1'b0;
        next_trap_to_level_two = 1'b0;
        next_trap_class        = 6'h00;
        next_read_data         = 64'h0000_0000_0000_0000;
        if (READ_REQUEST)
        begin
            if (trap_now)
            begin
                // RULE11 trap with syndrome class
                next_trap              = 1'b1;
                next_trap_to_level_two = trap_el2;
                next_trap_class        = `TRAP_SYNDROME_CLASS;
            end
            else
            begin
                next_read_valid        = 1'b1;
                next_read_data         = image;
            end
        end
    end

    // answer stands one cycle after the request edge
    always @(posedge REF_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            READ_DATA         <= 64'h0000_0000_0000_0000;
            READ_VALID        <= 1'b0;
            TRAP              <= 1'b0;
            TRAP_TO_LEVEL_TWO <= 1'b0;
            TRAP_CLASS        <= 6'h00;
        end
        else
        begin
            READ_DATA         <= next_read_data;
            READ_VALID        <= next_read_valid;
            TRAP              <= next_trap;
            TRAP_TO_LEVEL_TWO <= next_trap_to_level_two;
            TRAP_CLASS        <= next_trap_class;
        end
    end

endmodule // vector_feature_id_register

// ---- test/vector_feature_id_register_chk.sv ----
`timescale 1ns/1ps
module vector_feature_id_register_chk(input logic REF_CLK, RESETN, READ_REQUEST,
    LEVEL_TWO_ENABLED, ID_GROUP_THREE_TRAP, READ_VALID, TRAP, TRAP_TO_LEVEL_TWO,
    input logic [1:0] EXCEPTION_LEVEL, input logic [5:0] TRAP_CLASS,
    input logic [63:0] READ_DATA);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RESETN);
    wire t1 = EXCEPTION_LEVEL == 2'h1 && LEVEL_TWO_ENABLED && ID_GROUP_THREE_TRAP;
    a_read_ok: assert property (READ_REQUEST && EXCEPTION_LEVEL != 2'h0 && !t1
        |=> READ_VALID && !TRAP) else $error("read lost");
    a_el0_trap: assert property (READ_REQUEST && EXCEPTION_LEVEL == 2'h0
        |=> TRAP && !READ_VALID) else $error("el0 trap");
    a_el1_trap: assert property (READ_REQUEST && t1
        |=> TRAP && TRAP_TO_LEVEL_TWO) else $error("el1 trap");
    a_idle_quiet: assert property (!READ_REQUEST |=> !READ_VALID && !TRAP)
        else $error("spurious");
    a_trap_class: assert property (TRAP_CLASS == (TRAP ? 6'h18 : 6'h0))
        else $error("class");
    a_resv_zero: assert property (READ_DATA[63:48] == 0 && READ_DATA[39:36] == 0
        && READ_DATA[31:24] == 0) else $error("reserved");
    a_fixed_fields: assert property (READ_VALID && READ_DATA != 0
        |-> READ_DATA[47:44] == 4'h1 && READ_DATA[23:16] == 8'h11) else $error("fixed");
    a_build_parameter_a_pair: assert property (READ_DATA[43:40] == READ_DATA[35:32])
        else $error("build_parameter_a");
endmodule // vector_feature_id_register_chk
bind vector_feature_id_register vector_feature_id_register_chk u_chk(.*);

// ---- test/test_vector_feature_id_register.sv ----
`timescale 1ns/1ps
module test_vector_feature_id_register;
    logic REF_CLK = 0, RESETN = 0, BUILD_PARAMETER_A_DISABLE_INPUT = 0, VECTOR_PRESENT = 1;
    logic READ_REQUEST = 0, LEVEL_TWO_ENABLED = 0, ID_GROUP_THREE_TRAP = 0;
    logic HOST_TRAP_GENERAL = 0, READ_VALID, TRAP, TRAP_TO_LEVEL_TWO;
    logic [1:0] EXCEPTION_LEVEL = 0;
    logic [5:0] TRAP_CLASS;
    logic [63:0] READ_DATA, on = 64'h0000_1101_0011_0000, off = 64'h0000_1000_0011_0000;
    int errors = 0, n_checks = 0;
    always #20 REF_CLK = ~REF_CLK;
    vector_feature_id_register u_dut(.*);
    task chk(logic [73:0] g, e);
        n_checks++;
        if (g !== e) begin errors++; $display("mismatch %0t %h %h", $time, g, e); end
    endtask
    // t is {trap, to level two}; request held high across back-to-back reads
    task rd(logic [1:0] l, logic [63:0] d, logic [1:0] t);
        EXCEPTION_LEVEL = l; READ_REQUEST = 1;
        @(posedge REF_CLK) #1;
        chk({READ_VALID, TRAP, TRAP_TO_LEVEL_TWO, TRAP_CLASS, READ_DATA},
            {!t[1], t, t[1] ? 6'h18 : 6'h0, d});
    endtask
    task idle;
        READ_REQUEST = 0;
        @(posedge REF_CLK) #1 chk({TRAP, READ_VALID}, 0);
    endtask
    task rst(logic s);
        RESETN = 0; BUILD_PARAMETER_A_DISABLE_INPUT = s;
        repeat (16) @(posedge REF_CLK);
        #1 RESETN = 1;
        repeat (2) @(posedge REF_CLK);
        #1;
    endtask
    task t_levels;
        rd(1, on, 0); rd(2, on, 0); rd(3, on, 0);
        VECTOR_PRESENT = 0; rd(2, 0, 0); VECTOR_PRESENT = 1; idle;
    endtask
    task t_traps;
        LEVEL_TWO_ENABLED = 1; rd(0, 0, 2);
        HOST_TRAP_GENERAL = 1; rd(0, 0, 3); rd(1, on, 0);
        ID_GROUP_THREE_TRAP = 1; rd(1, 0, 3); rd(3, on, 0);
        LEVEL_TWO_ENABLED = 0; rd(1, on, 0); idle;
    endtask
    task t_build_parameter_a;
        rst(1); rd(1, off, 0);
        BUILD_PARAMETER_A_DISABLE_INPUT = 0; rd(2, off, 0); idle;
        rst(0); rd(3, on, 0); idle;
    endtask
    task complete_run;
        $display("errors %0d checks %0d", errors, n_checks);
        if (errors == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin rst(0); t_levels; t_traps; t_build_parameter_a; complete_run; end
    initial begin #100000; errors++; complete_run; end
endmodule // test_vector_feature_id_register
